/* File: logic/mrb_pkg.sv */
package mrb_pkg;
    // Printed offsets are word indices; byte address is four times the index
    localparam logic [8:0] IDX_FREQ_INSTANT = 9'h0cb;
    localparam logic [8:0] IDX_ACTIVE_POWER_A_INSTANT = 9'h0cc;
    localparam logic [8:0] IDX_REACTIVE_POWER_INSTANT = 9'h0cd;
    localparam logic [8:0] IDX_CURRENT_RMS_A_INSTANT = 9'h0ce;
    localparam logic [8:0] IDX_VOLTAGE_RMS_INSTANT = 9'h0cf;
    localparam logic [8:0] IDX_ACTIVE_POWER_A_AVERAGE = 9'h0d0;
    localparam logic [8:0] IDX_REACTIVE_POWER_AVERAGE = 9'h0d1;
    localparam logic [8:0] IDX_FREQ_AVERAGE = 9'h0d2;
    localparam logic [8:0] IDX_CURRENT_RMS_A_AVERAGE = 9'h0d3;
    localparam logic [8:0] IDX_VOLTAGE_RMS_AVERAGE = 9'h0d4;
    localparam logic [8:0] IDX_VOLTAGE_DC_INSTANT = 9'h0d9;
    localparam logic [8:0] IDX_CURRENT_A_DC_INSTANT = 9'h0da;
    localparam logic [8:0] IDX_STATUS_FLAG_CLEAR = 9'h19d;
    localparam logic [8:0] IDX_IRQ_STATUS = 9'h1a0;
    localparam logic [8:0] IDX_IRQ_MASK = 9'h1a1;
    localparam int NUM_RESULTS = 12;
    localparam int BIT_PHASE_DONE = 9;
    localparam int BIT_POWER_DOWN = 6;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Metering clock and refresh periods
    localparam longint METER_CLK_HZ = 3276800;
    localparam int SYS_CLK_HZ = 40000000;
    localparam int PERIOD_FREQ_INST_MS = 20;
    localparam int PERIOD_POWER_INST_MS = 160;
    localparam int PERIOD_RMS_INST_MS = 10;
    localparam int PERIOD_POWER_AVG_MS = 640;
    localparam int PERIOD_FREQ_AVG_MS = 320;
    localparam int PERIOD_RMS_AVG_MS = 320;
    localparam int SETTLE_POWER_INST_MS = 480;
    localparam int SETTLE_RMS_INST_MS = 160;
    localparam int SETTLE_POWER_AVG_MS = 1280;
    localparam int SETTLE_RMS_AVG_MS = 960;
    // Base tick is 10 ms; each refresh period is a whole multiple of it
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_FREQ_INST = PERIOD_FREQ_INST_MS / TICK_MS;
    localparam int TICKS_POWER_INST = PERIOD_POWER_INST_MS / TICK_MS;
    localparam int TICKS_RMS_INST = PERIOD_RMS_INST_MS / TICK_MS;
    localparam int TICKS_POWER_AVG = PERIOD_POWER_AVG_MS / TICK_MS;
    localparam int TICKS_FREQ_AVG = PERIOD_FREQ_AVG_MS / TICK_MS;
    localparam int TICKS_RMS_AVG = PERIOD_RMS_AVG_MS / TICK_MS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/mrb_result_bank.sv */
module mrb_result_bank #(
    parameter int TICK_CYCLES = mrb_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic rxReset,
    input wire logic swReset,
    input wire logic [31:0] meterFreq,
    input wire logic [31:0] meterActivePower,
    input wire logic [31:0] meterReactivePower,
    input wire logic [31:0] meterCurrentRms,
    input wire logic [31:0] meterVoltageRms,
    input wire logic [31:0] meterVoltageDc,
    input wire logic [31:0] meterCurrentDc,
    input wire logic phaseDone,
    input wire logic powerDown,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    if (TICK_CYCLES < 2 || TICK_CYCLES > 16777215) begin : gTickRange
        $error("TICK_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [23:0] tickCnt;
        logic [5:0] tickNum;
        logic [11:0][31:0] result;
        logic phaseDoneLatched;
        logic powerDownLatched;
        logic [1:0] irqStatus;
        logic [1:0] irqMask;
        logic awHeld;
        logic [8:0] awIdx;
        logic awBad;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic phaseSync1;
        logic phaseSync2;
        logic pdSync1;
        logic pdSync2;
        logic phasePrev;
        logic pdPrev;
    } mrb_state_t;

    mrb_state_t state_q;
    mrb_state_t state_d;
    logic anyReset;
    logic tick;
    logic [11:0] refresh;
    logic [11:0][31:0] source;
    logic writeFire;
    logic phaseSet;
    logic pdSet;
    logic [31:0] clearWord;
    logic [31:0] readWord;
    logic readHit;
    logic writeHit;
    logic [31:0] wMask;

    assign anyReset = srst || rxReset || swReset;
    assign tick = (state_q.tickCnt == 24'(TICK_CYCLES - 1));
    assign source = {meterCurrentDc, meterVoltageDc, meterVoltageRms, meterCurrentRms,
        meterFreq, meterReactivePower, meterActivePower, meterVoltageRms,
        meterCurrentRms, meterReactivePower, meterActivePower, meterFreq};

    ////////////////////////////////////////////////////////////////////////////
    // Refresh strobes, each a multiple of the 10 ms tick; tickNum wraps at 64
    // so every period (1,2,16,32,64 ticks) divides it evenly.
    always_comb begin
        refresh[0] = tick && (state_q.tickNum % mrb_pkg::TICKS_FREQ_INST
            == mrb_pkg::TICKS_FREQ_INST - 1);
        refresh[1] = tick && (state_q.tickNum % mrb_pkg::TICKS_POWER_INST
            == mrb_pkg::TICKS_POWER_INST - 1);
        refresh[2] = refresh[1];
        refresh[3] = tick;
        refresh[4] = tick;
        refresh[5] = tick && (state_q.tickNum % mrb_pkg::TICKS_POWER_AVG
            == mrb_pkg::TICKS_POWER_AVG - 1);
        refresh[6] = refresh[5];
        refresh[7] = tick && (state_q.tickNum % mrb_pkg::TICKS_FREQ_AVG
            == mrb_pkg::TICKS_FREQ_AVG - 1);
        refresh[8] = tick && (state_q.tickNum % mrb_pkg::TICKS_RMS_AVG
            == mrb_pkg::TICKS_RMS_AVG - 1);
        refresh[9] = refresh[8];
        refresh[10] = tick;
        refresh[11] = tick;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        readHit = 1'b1;
        readWord = 32'h0000_0000;
        case (s_axi_araddr[10:2])
            mrb_pkg::IDX_FREQ_INSTANT: readWord = state_q.result[0];
            mrb_pkg::IDX_ACTIVE_POWER_A_INSTANT: readWord = state_q.result[1];
            mrb_pkg::IDX_REACTIVE_POWER_INSTANT: readWord = state_q.result[2];
            mrb_pkg::IDX_CURRENT_RMS_A_INSTANT: readWord = state_q.result[3];
            mrb_pkg::IDX_VOLTAGE_RMS_INSTANT: readWord = state_q.result[4];
            mrb_pkg::IDX_ACTIVE_POWER_A_AVERAGE: readWord = state_q.result[5];
            mrb_pkg::IDX_REACTIVE_POWER_AVERAGE: readWord = state_q.result[6];
            mrb_pkg::IDX_FREQ_AVERAGE: readWord = state_q.result[7];
            mrb_pkg::IDX_CURRENT_RMS_A_AVERAGE: readWord = state_q.result[8];
            mrb_pkg::IDX_VOLTAGE_RMS_AVERAGE: readWord = state_q.result[9];
            mrb_pkg::IDX_VOLTAGE_DC_INSTANT: readWord = state_q.result[10];
            mrb_pkg::IDX_CURRENT_A_DC_INSTANT: readWord = state_q.result[11];
            mrb_pkg::IDX_STATUS_FLAG_CLEAR: begin
                // Reserved bits read as zero; software must not rely on it
                readWord[mrb_pkg::BIT_PHASE_DONE] = state_q.phaseDoneLatched;
                readWord[mrb_pkg::BIT_POWER_DOWN] = state_q.powerDownLatched;
            end
            mrb_pkg::IDX_IRQ_STATUS: readWord[1:0] = state_q.irqStatus;
            mrb_pkg::IDX_IRQ_MASK: readWord[1:0] = state_q.irqMask;
            default: readHit = 1'b0;
        endcase
        if (s_axi_araddr[31:11] != 21'h0 || s_axi_araddr[1:0] != 2'h0) begin
            readHit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign writeFire = state_q.awHeld && state_q.wHeld && !state_q.bValid;
    assign phaseSet = state_q.phaseSync2 && !state_q.phasePrev;
    assign pdSet = state_q.pdSync2;
    assign wMask = {{8{state_q.wStrb[3]}}, {8{state_q.wStrb[2]}}, {8{state_q.wStrb[1]}},
        {8{state_q.wStrb[0]}}};
    // Each byte lane clears only the flags that it carries
    assign clearWord = (writeFire && !state_q.awBad
        && state_q.awIdx == mrb_pkg::IDX_STATUS_FLAG_CLEAR)
        ? (state_q.wData & wMask) : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode: result words answer OKAY but keep their value
    always_comb begin
        writeHit = 1'b0;
        case (state_q.awIdx)
            mrb_pkg::IDX_FREQ_INSTANT,
            mrb_pkg::IDX_ACTIVE_POWER_A_INSTANT,
            mrb_pkg::IDX_REACTIVE_POWER_INSTANT,
            mrb_pkg::IDX_CURRENT_RMS_A_INSTANT,
            mrb_pkg::IDX_VOLTAGE_RMS_INSTANT,
            mrb_pkg::IDX_ACTIVE_POWER_A_AVERAGE,
            mrb_pkg::IDX_REACTIVE_POWER_AVERAGE,
            mrb_pkg::IDX_FREQ_AVERAGE,
            mrb_pkg::IDX_CURRENT_RMS_A_AVERAGE,
            mrb_pkg::IDX_VOLTAGE_RMS_AVERAGE,
            mrb_pkg::IDX_VOLTAGE_DC_INSTANT,
            mrb_pkg::IDX_CURRENT_A_DC_INSTANT,
            mrb_pkg::IDX_STATUS_FLAG_CLEAR,
            mrb_pkg::IDX_IRQ_STATUS,
            mrb_pkg::IDX_IRQ_MASK: writeHit = !state_q.awBad;
            default: writeHit = 1'b0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        state_d.phaseSync1 = phaseDone;
        state_d.phaseSync2 = state_q.phaseSync1;
        state_d.pdSync1 = powerDown;
        state_d.pdSync2 = state_q.pdSync1;
        state_d.phasePrev = state_q.phaseSync2;
        state_d.pdPrev = state_q.pdSync2;
        state_d.tickCnt = tick ? 24'h0 : state_q.tickCnt + 24'h1;
        if (tick) begin
            state_d.tickNum = state_q.tickNum + 6'h1;
        end
        for (int i = 0; i < mrb_pkg::NUM_RESULTS; i++) begin
            if (refresh[i]) begin
                state_d.result[i] = source[i];
            end
        end
        // Clear first, then set so a coincident event survives
        if (clearWord[mrb_pkg::BIT_PHASE_DONE]) begin
            state_d.phaseDoneLatched = 1'b0;
        end
        if (phaseSet) begin
            state_d.phaseDoneLatched = 1'b1;
        end
        if (clearWord[mrb_pkg::BIT_POWER_DOWN]) begin
            state_d.powerDownLatched = 1'b0;
        end
        if (pdSet) begin
            state_d.powerDownLatched = 1'b1;
        end
        // Interrupt status: bit0 phase done, bit1 power down; write one clears
        if (writeFire && !state_q.awBad && state_q.awIdx == mrb_pkg::IDX_IRQ_STATUS
                && state_q.wStrb[0]) begin
            state_d.irqStatus = state_q.irqStatus & ~state_q.wData[1:0];
        end
        if (phaseSet) begin
            state_d.irqStatus[0] = 1'b1;
        end
        if (pdSet && !state_q.pdPrev) begin
            state_d.irqStatus[1] = 1'b1;
        end
        if (writeFire && !state_q.awBad && state_q.awIdx == mrb_pkg::IDX_IRQ_MASK
                && state_q.wStrb[0]) begin
            state_d.irqMask = state_q.wData[1:0];
        end
        // AXI write: address and data taken in either order, answer after both
        if (s_axi_awvalid && !state_q.awHeld) begin
            state_d.awHeld = 1'b1;
            state_d.awIdx = s_axi_awaddr[10:2];
            state_d.awBad = s_axi_awaddr[31:11] != 21'h0 || s_axi_awaddr[1:0] != 2'h0;
        end
        if (s_axi_wvalid && !state_q.wHeld) begin
            state_d.wHeld = 1'b1;
            state_d.wData = s_axi_wdata;
            state_d.wStrb = s_axi_wstrb;
        end
        if (writeFire) begin
            state_d.bValid = 1'b1;
            // Result words are read-only: writes are accepted but change nothing
            state_d.bResp = writeHit ? mrb_pkg::RESP_OKAY : mrb_pkg::RESP_SLVERR;
            state_d.awHeld = 1'b0;
            state_d.wHeld = 1'b0;
        end
        if (state_q.bValid && s_axi_bready) begin
            state_d.bValid = 1'b0;
        end
        if (s_axi_arvalid && !state_q.rValid) begin
            state_d.rValid = 1'b1;
            state_d.rData = readHit ? readWord : 32'h0000_0000;
            state_d.rResp = readHit ? mrb_pkg::RESP_OKAY : mrb_pkg::RESP_SLVERR;
        end
        if (state_q.rValid && s_axi_rready) begin
            state_d.rValid = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (anyReset) begin
            state_q <= '0;
            state_q.irqStatus <= mrb_pkg::IRQ_RESET;
            state_q.irqMask <= mrb_pkg::IRQ_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign s_axi_awready = !state_q.awHeld;
    assign s_axi_wready = !state_q.wHeld;
    assign s_axi_bvalid = state_q.bValid;
    assign s_axi_bresp = state_q.bResp;
    assign s_axi_arready = !state_q.rValid;
    assign s_axi_rvalid = state_q.rValid;
    assign s_axi_rdata = state_q.rData;
    assign s_axi_rresp = state_q.rResp;
    assign irq = |(state_q.irqStatus & state_q.irqMask);

    ////////////////////////////////////////////////////////////////////////////
    sequence seqClearPhase;
        clearWord[mrb_pkg::BIT_PHASE_DONE] && !phaseSet;
    endsequence

    AST_RESET_CLEARS: assert property (@(posedge clock) anyReset |=>
        state_q.result[0] == 32'h0 && !state_q.phaseDoneLatched && !irq)
        else $error("reset did not clear bank");
    AST_FREQ_INST_HOLD: assert property (@(posedge clock) disable iff (anyReset)
        !refresh[0] |=> state_q.result[0] == $past(state_q.result[0]))
        else $error("instant frequency changed off its refresh");
    AST_POWER_INST_LOAD: assert property (@(posedge clock) disable iff (anyReset)
        refresh[1] |=> state_q.result[1] == $past(meterActivePower))
        else $error("instant power not loaded");
    AST_RMS_PAIR: assert property (@(posedge clock) disable iff (anyReset)
        tick |=> state_q.result[3] == $past(meterCurrentRms)
        && state_q.result[4] == $past(meterVoltageRms))
        else $error("instant RMS not loaded");
    AST_POWER_AVG_RARE: assert property (@(posedge clock) disable iff (anyReset)
        refresh[5] |-> refresh[1] && refresh[7])
        else $error("average power refresh out of step");
    AST_FREQ_AVG_LOAD: assert property (@(posedge clock) disable iff (anyReset)
        refresh[7] |=> state_q.result[7] == $past(meterFreq))
        else $error("average frequency not loaded");
    AST_RMS_AVG_HOLD: assert property (@(posedge clock) disable iff (anyReset)
        !refresh[8] |=> $stable(state_q.result[8]))
        else $error("average RMS changed off its refresh");
    AST_RO_WRITE: assert property (@(posedge clock) disable iff (anyReset)
        writeFire && !tick |=> $stable(state_q.result))
        else $error("write altered a result");
    AST_PHASE_CLEAR: assert property (@(posedge clock) disable iff (anyReset)
        seqClearPhase |=> !state_q.phaseDoneLatched)
        else $error("phase done latch not cleared");
    AST_SET_WINS: assert property (@(posedge clock) disable iff (anyReset)
        pdSet |=> state_q.powerDownLatched)
        else $error("power down set lost");
    AST_PD_PERSIST: assert property (@(posedge clock) disable iff (anyReset)
        state_q.powerDownLatched && !clearWord[mrb_pkg::BIT_POWER_DOWN]
        |=> state_q.powerDownLatched)
        else $error("power down latch dropped");
    AST_PHASE_SET_WINS: assert property (@(posedge clock) disable iff (anyReset)
        phaseSet |=> state_q.phaseDoneLatched)
        else $error("phase done set lost");
    AST_PHASE_HOLD: assert property (@(posedge clock) disable iff (anyReset)
        state_q.phaseDoneLatched && !clearWord[mrb_pkg::BIT_PHASE_DONE]
        |=> state_q.phaseDoneLatched)
        else $error("phase done latch dropped");
    AST_PD_CLEAR: assert property (@(posedge clock) disable iff (anyReset)
        clearWord[mrb_pkg::BIT_POWER_DOWN] && !pdSet |=> !state_q.powerDownLatched)
        else $error("power down latch not cleared");
    AST_DC_LOAD: assert property (@(posedge clock) disable iff (anyReset)
        refresh[10] |=> state_q.result[10] == $past(meterVoltageDc)
        && state_q.result[11] == $past(meterCurrentDc))
        else $error("DC component not loaded");
    AST_IRQ_SETS: assert property (@(posedge clock) disable iff (anyReset)
        phaseSet |=> state_q.irqStatus[0])
        else $error("phase done interrupt lost");

    // Bus answers: one answer per request, released once taken
    sequence seqWriteDone;
        s_axi_bvalid && s_axi_bready;
    endsequence

    sequence seqReadDone;
        s_axi_rvalid && s_axi_rready;
    endsequence

    AST_WRITE_ANSWER: assert property (@(posedge clock) disable iff (anyReset)
        writeFire |=> s_axi_bvalid)
        else $error("write response missing");
    AST_B_RELEASE: assert property (@(posedge clock) disable iff (anyReset)
        seqWriteDone |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_READ_ANSWER: assert property (@(posedge clock) disable iff (anyReset)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    AST_R_RELEASE: assert property (@(posedge clock) disable iff (anyReset)
        seqReadDone |=> !s_axi_rvalid)
        else $error("read response repeated");
    AST_READ_ERR: assert property (@(posedge clock) disable iff (anyReset)
        s_axi_arvalid && s_axi_arready && !readHit
        |=> s_axi_rresp == mrb_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

/* File: tb/test_metering_result_register_bank.sv */
module test_metering_result_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 20;
    localparam logic [8:0] IDX_TAB [12] = '{mrb_pkg::IDX_FREQ_INSTANT,
        mrb_pkg::IDX_ACTIVE_POWER_A_INSTANT, mrb_pkg::IDX_REACTIVE_POWER_INSTANT,
        mrb_pkg::IDX_CURRENT_RMS_A_INSTANT, mrb_pkg::IDX_VOLTAGE_RMS_INSTANT,
        mrb_pkg::IDX_ACTIVE_POWER_A_AVERAGE, mrb_pkg::IDX_REACTIVE_POWER_AVERAGE,
        mrb_pkg::IDX_FREQ_AVERAGE, mrb_pkg::IDX_CURRENT_RMS_A_AVERAGE,
        mrb_pkg::IDX_VOLTAGE_RMS_AVERAGE, mrb_pkg::IDX_VOLTAGE_DC_INSTANT,
        mrb_pkg::IDX_CURRENT_A_DC_INSTANT};
    localparam int SRC_TAB [12] = '{0, 1, 2, 3, 4, 1, 2, 0, 3, 4, 5, 6};
    // Refresh period of each of the first ten results, in ticks (the two DC results are not listed)
    localparam int PER_TAB [10] = '{2, 16, 16, 1, 1, 64, 64, 32, 32, 32};
    localparam logic [1:0] OK = mrb_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = mrb_pkg::RESP_SLVERR;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic rxReset = 1'b0;
    logic swReset = 1'b0;
    logic phaseDone = 1'b0;
    logic powerDown = 1'b0;
    logic [31:0] meterIn [7] = '{default: 32'h0};
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int errors = 0;
    int samplesChecked = 0;
    int cycleCount = 0;

    mrb_result_bank #(.TICK_CYCLES(TICK)) DUT (.clock(clock), .srst(srst), .rxReset(rxReset),
        .swReset(swReset), .meterFreq(meterIn[0]), .meterActivePower(meterIn[1]),
        .meterReactivePower(meterIn[2]), .meterCurrentRms(meterIn[3]),
        .meterVoltageRms(meterIn[4]), .meterVoltageDc(meterIn[5]), .meterCurrentDc(meterIn[6]),
        .phaseDone(phaseDone), .powerDown(powerDown), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) cycleCount <= cycleCount + 1;

    function automatic logic [31:0] addrOf(input logic [8:0] idx);
        return {21'h0, idx, 2'h0};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic axiWrite(input logic [8:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge clock);
        awaddr <= addrOf(idx);
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w)) begin
            @(posedge clock);
            if (!a && awready === 1'b1) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clock);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic axiRead(input logic [8:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= addrOf(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clock);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdChk(input logic [8:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(idx, d, r);
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk("rdata", exp, d);
    endtask

    // Reserved bits of the status words are not compared: software must not rely on them
    task automatic bitChk(input logic [8:0] idx, input int b, input logic e);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(idx, d, r);
        chk("status bit", {31'h0, e}, {31'h0, d[b]});
    endtask

    task automatic pollFor(input logic [8:0] idx, input logic [31:0] exp, output int t);
        logic [31:0] d;
        logic [1:0] r;
        int lim;
        lim = cycleCount + 2 * 64 * TICK + 100;
        do axiRead(idx, d, r); while (d !== exp && cycleCount < lim);
        t = cycleCount;
        chk("polled result", exp, d);
    endtask

    task automatic giveVerdict();
        if (errors == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        giveVerdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int t1, t2, p, dt;
        logic [31:0] a;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 12; i++) rdChk(IDX_TAB[i], mrb_pkg::RESULT_RESET, OK);
        for (int k = 0; k < 7; k++) meterIn[k] <= 32'h8000_0000 | k;
        repeat (64 * TICK + 40) @(posedge clock);
        for (int i = 0; i < 12; i++) begin
            rdChk(IDX_TAB[i], 32'h8000_0000 | SRC_TAB[i], OK);
            axiWrite(IDX_TAB[i], 32'h1234_5678, OK);
            rdChk(IDX_TAB[i], 32'h8000_0000 | SRC_TAB[i], OK);
        end
        rdChk(9'h100, 32'h0, ERR);
        axiWrite(9'h100, 32'h1, ERR);
        // Measure the spacing of two successive loads; read latency cancels out
        for (int i = 0; i < 10; i++) begin
            a = 32'hf000_0000 + 32'(i * 2);
            p = PER_TAB[i] * TICK;
            meterIn[SRC_TAB[i]] <= a;
            pollFor(IDX_TAB[i], a, t1);
            meterIn[SRC_TAB[i]] <= a + 32'h1;
            pollFor(IDX_TAB[i], a + 32'h1, t2);
            dt = t2 - t1;
            chk("refresh period", p, (dt >= p - 8 && dt <= p + 8) ? p : dt);
        end
        phaseDone <= 1'b1;
        repeat (3) @(posedge clock);
        phaseDone <= 1'b0;
        repeat (4) @(posedge clock);
        bitChk(mrb_pkg::IDX_STATUS_FLAG_CLEAR, mrb_pkg::BIT_PHASE_DONE, 1'b1);
        axiWrite(mrb_pkg::IDX_STATUS_FLAG_CLEAR, 32'h0, OK);
        bitChk(mrb_pkg::IDX_STATUS_FLAG_CLEAR, mrb_pkg::BIT_PHASE_DONE, 1'b1);
        axiWrite(mrb_pkg::IDX_STATUS_FLAG_CLEAR, 32'h0000_0200, OK);
        bitChk(mrb_pkg::IDX_STATUS_FLAG_CLEAR, mrb_pkg::BIT_PHASE_DONE, 1'b0);
        powerDown <= 1'b1;
        repeat (5) @(posedge clock);
        axiWrite(mrb_pkg::IDX_STATUS_FLAG_CLEAR, 32'h0000_0040, OK);
        bitChk(mrb_pkg::IDX_STATUS_FLAG_CLEAR, mrb_pkg::BIT_POWER_DOWN, 1'b1);
        powerDown <= 1'b0;
        repeat (5) @(posedge clock);
        bitChk(mrb_pkg::IDX_STATUS_FLAG_CLEAR, mrb_pkg::BIT_POWER_DOWN, 1'b1);
        axiWrite(mrb_pkg::IDX_STATUS_FLAG_CLEAR, 32'h0000_0040, OK);
        bitChk(mrb_pkg::IDX_STATUS_FLAG_CLEAR, mrb_pkg::BIT_POWER_DOWN, 1'b0);
        rdChk(mrb_pkg::IDX_IRQ_MASK, 32'h0, OK);
        rdChk(mrb_pkg::IDX_IRQ_STATUS, 32'h3, OK);
        chk("irq masked", 32'h0, {31'h0, irq});
        axiWrite(mrb_pkg::IDX_IRQ_MASK, 32'h1, OK);
        repeat (2) @(posedge clock);
        chk("irq raised", 32'h1, {31'h0, irq});
        axiWrite(mrb_pkg::IDX_IRQ_STATUS, 32'h1, OK);
        repeat (2) @(posedge clock);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdChk(mrb_pkg::IDX_IRQ_STATUS, 32'h2, OK);
        for (int j = 0; j < 2; j++) begin
            axiWrite(mrb_pkg::IDX_IRQ_MASK, 32'h3, OK);
            repeat (64 * TICK + 40) @(posedge clock);
            rdChk(mrb_pkg::IDX_ACTIVE_POWER_A_AVERAGE, meterIn[1], OK);
            @(posedge clock);
            rxReset <= (j == 0);
            swReset <= (j == 1);
            @(posedge clock);
            rxReset <= 1'b0;
            swReset <= 1'b0;
            rdChk(mrb_pkg::IDX_ACTIVE_POWER_A_AVERAGE, mrb_pkg::RESULT_RESET, OK);
            rdChk(mrb_pkg::IDX_IRQ_MASK, 32'h0, OK);
            chk("irq after reset", 32'h0, {31'h0, irq});
        end
        giveVerdict();
    end
endmodule
